//--- rtl/rat_aux_timers.sv
// auxiliary timers: second alarm, watchdog, countdown timer, square wave
//
// Functional notes
// R1 - alarm-two enable maps 14h-18h as alarm two
// R2 - enable clear at reset; bytes are sram
// R3 - repeat bits pick second to year matching
// R4 - watchdog byte: multiplier high, resolution low
// R5 - timeout is multiplier times resolution, flags
// R6 - any watchdog write restarts timeout
// R7 - writing zero releases irq, disables watchdog
// R8 - flags read clears watchdog flag
// R9 - reset clears watchdog register
// R10 - programmed watchdog overrides frequency test; code does so only while squareOutputEnable is low
// R11 - timer runs on enable, stops at power-down
// R12 - clock select: 4096, 64, 1, 1/60 Hz
// R13 - count to end, set flag, auto reload
// R14 - period is n over clock; zero stops
// R15 - timer read returns live count
// R16 - host serial clock twice timer clock
// R17 - only flags read clears timer flag
// R18 - level mode irq follows flag and enable
// R19 - pulse width per clock and count
// R20 - pulses stop only on mode bits cleared
// R21 - rate field selects square wave frequency
// R22 - square output needs enable, no power fail
// R23 - flags read releases alarm irq
// R24 - no source enabled: pin follows static bit
// R25 - irq active low, held by steady sources
`timescale 1ns/10ps
module rat_aux_timers
    import rat_pkg::*;
(
    input  wire logic        clk_sys,            // 20 MHz clock
    input  wire logic        rst,                // async reset, high
    input  wire rat_regreq_t regReq,             // register request
    output logic [7:0]       regRdData,          // read data
    input  wire logic [4:0]  alarmOneMatch,      // field equal, alarm one
    input  wire logic [4:0]  alarmTwoMatch,      // field equal, alarm two
    input  wire logic [4:0]  alarmOneRepeat,     // alarm one repeat bits
    input  wire logic        alarmOneIrqEnable,  // alarm irq enable
    input  wire logic        oscFailFlag,        // oscillator fail flag
    input  wire logic        oscFailIrqEnable,   // osc fail irq enable
    input  wire logic        batteryLowFlag,     // battery low flag
    input  wire logic        staticOutBit,       // static output level
    input  wire logic        freqTestEnable,     // frequency test enable
    input  wire logic        squareOutputEnable, // square wave enable
    input  wire logic        powerFailPin,       // switchover, async
    output logic             squareOutputPin,    // square wave out
    output logic             sharedIrqPinOut,    // open drain level
    output logic             sharedIrqPinOe      // high while pulling low
);

    localparam rat_state_t RESET_STATE = '{
        wdState : WD_IDLE,
        tmrCtl  : CTL_RESET,
        cfg     : CFG_RESET,
        default : '0
    };

    rat_state_t  q;
    rat_state_t  d;
    logic [24:0] accSum;
    logic        presTick;
    logic        tick4096;
    logic        tick64;
    logic        tick16Hz;
    logic        tick4Hz;
    logic        tick1Hz;
    logic        tickQHz;
    logic        tickMin;
    logic        tmrTick;
    logic        wdTick;
    logic        ctlTe;
    logic        ctlTp;
    logic        ctlTie;
    logic        pulseMode;
    logic        wrWdog;
    logic        wrTval;
    logic        wrSram;
    logic        flagRead;
    logic        wdSet;
    logic        tmrRun;
    logic        tmrEnd;
    logic        al1Set;
    logic        al2Set;
    logic [4:0]  rptTwo;
    logic [4:0]  wdMult;
    logic        wdProg;
    logic        srcEnabled;
    logic        ftOn;
    logic        holdLow;
    logic        tmrIrq;

    // true when the low k prescaler bits are all ones
    function automatic logic lowOnes(input logic [17:0] cnt,
                                     input int unsigned k);
        logic [17:0] m;
        m = 18'((32'd1 << k) - 32'd1);
        return (cnt & m) == m;
    endfunction

    // unlisted repeat codes fall back to once per second
    function automatic logic alarmHit(input logic [4:0] rpt,
                                      input logic [4:0] eq);
        logic [4:0] r;
        r = rpt;
        if (!(rpt == RPT_SEC || rpt == RPT_MIN || rpt == RPT_HOUR ||
              rpt == RPT_DAY || rpt == RPT_MONTH || rpt == RPT_YEAR)) begin
            r = RPT_SEC;
        end
        return &(eq | r); // R3
    endfunction

    // prescaler bit whose toggle rate matches the rate code
    function automatic int unsigned sqBit(input logic [3:0] code);
        return (code == 4'h1) ? 0 : int'(code); // R21
    endfunction

    // pulse length in prescaler ticks
    function automatic logic [10:0] pulseTicks(input logic [1:0] td,
                                               input logic       one);
        logic [10:0] w;
        w = PULSE_64;
        if (td == 2'b00) begin
            w = one ? PULSE_8192 : PULSE_4096;
        end else if (td == 2'b01) begin
            w = one ? PULSE_128 : PULSE_64;
        end
        return w; // R19
    endfunction

    // divider ticks, all one-cycle enables of clk_sys
    assign accSum   = q.presAcc + ACC_STEP;
    assign presTick = accSum >= ACC_MOD;
    assign tick4096 = presTick & lowOnes(q.presc, DIV_4096);
    assign tick64   = presTick & lowOnes(q.presc, DIV_64);
    assign tick16Hz = presTick & lowOnes(q.presc, DIV_16HZ);
    assign tick4Hz  = presTick & lowOnes(q.presc, DIV_4HZ);
    assign tick1Hz  = presTick & lowOnes(q.presc, DIV_1HZ);
    assign tickQHz  = presTick & lowOnes(q.presc, DIV_QHZ);
    assign tickMin  = tick1Hz & (q.minCnt == MIN_LAST);

    // timer clock and watchdog resolution selects
    always_comb begin
        tmrTick = tickMin;
        wdTick  = tickQHz;
        case (q.tmrCtl[1:0])
            2'b00:   tmrTick = tick4096; // R12
            2'b01:   tmrTick = tick64;
            2'b10:   tmrTick = tick1Hz;
            default: tmrTick = tickMin;
        endcase
        case (q.wdReg[1:0])
            2'b00:   wdTick = tick16Hz; // R4
            2'b01:   wdTick = tick4Hz;
            2'b10:   wdTick = tick1Hz;
            default: wdTick = tickQHz;
        endcase
    end

    // decoded control and access strobes
    assign ctlTe     = q.tmrCtl[CTL_TE];
    assign ctlTp     = q.tmrCtl[CTL_TP];
    assign ctlTie    = q.tmrCtl[CTL_TIE];
    assign pulseMode = ctlTe & ctlTie & ctlTp;
    assign wrWdog    = regReq.write & (regReq.addr == ADDR_WDOG);
    assign wrTval    = regReq.write & (regReq.addr == ADDR_TVAL);
    assign wrSram    = regReq.write & (regReq.addr >= ADDR_AL2_FIRST) &
                       (regReq.addr <= ADDR_AL2_LAST);
    assign flagRead  = regReq.read & (regReq.addr == ADDR_FLAGS);
    assign wdMult    = q.wdReg[WD_MULT_LSB+4:WD_MULT_LSB];
    assign wdProg    = q.wdReg != 8'h00;

    // a write in the timeout cycle restarts instead of expiring
    assign wdSet  = (q.wdState == WD_RUN) & wdTick & !wrWdog &
                    (5'(q.wdCnt + 5'h01) == wdMult); // R5
    assign tmrRun = ctlTe & (q.tmrLoad != 8'h00) & !wrTval; // R11 R14
    assign tmrEnd = tmrRun & tmrTick & (q.tmrCnt <= 8'h01); // R13

    // alarm two repeat bits sit in bit 7, month byte first
    assign rptTwo = {q.sram[0][RPT_BIT], q.sram[1][RPT_BIT],
                     q.sram[2][RPT_BIT], q.sram[3][RPT_BIT],
                     q.sram[4][RPT_BIT]};
    assign al1Set = tick1Hz & alarmHit(alarmOneRepeat, alarmOneMatch);
    assign al2Set = tick1Hz & q.cfg[CFG_ALARM_TWO_ENABLE] &
                    alarmHit(rptTwo, alarmTwoMatch); // R1 R2

    // shared pin sources
    assign srcEnabled = oscFailIrqEnable | alarmOneIrqEnable | wdProg;
    assign ftOn    = freqTestEnable & staticOutBit &
                     !(wdProg & !squareOutputEnable); // R10
    assign tmrIrq  = ctlTie & (ctlTp ? (ctlTe & (q.pulseCnt != 11'h000))
                                     : q.tf); // R18 R20
    assign holdLow = (alarmOneIrqEnable & (q.af1 | q.af2)) | q.wdIrq |
                     (oscFailFlag & oscFailIrqEnable) |
                     (!srcEnabled & !staticOutBit); // R24 R25

    // next state
    always_comb begin
        d = q;
        // prescaler and minute divider
        d.presAcc = presTick ? 25'(accSum - ACC_MOD) : accSum;
        if (presTick) begin
            d.presc = 18'(q.presc + 18'h00001);
        end
        if (tick1Hz) begin
            d.minCnt = (q.minCnt == MIN_LAST) ? 6'h00
                                              : 6'(q.minCnt + 6'h01);
        end
        // power fail sync; a change counts once stages two and three agree
        d.pfS1 = powerFailPin;
        d.pfS2 = q.pfS1;
        d.pfS3 = q.pfS2;
        if (q.pfS2 == q.pfS3) begin
            d.pfStable = q.pfS2;
        end
        // watchdog counting
        unique case (q.wdState)
            WD_IDLE: begin
            end
            WD_RUN: begin
                if (wdSet) begin
                    d.wdIrq   = 1'b1; // R5
                    d.wdState = WD_EXPIRED;
                end else if (wdTick) begin
                    d.wdCnt = 5'(q.wdCnt + 5'h01);
                end
            end
            WD_EXPIRED: begin
            end
        endcase
        // a write with a nonzero multiplier restarts, any other disables; zero releases
        if (wrWdog) begin
            d.wdReg = regReq.data;
            d.wdCnt = 5'h00; // R6
            if (regReq.data == 8'h00) begin
                d.wdIrq = 1'b0; // R7
            end
            d.wdState = (regReq.data[WD_MULT_LSB+4:WD_MULT_LSB] == 5'h00)
                        ? WD_IDLE : WD_RUN;
        end
        // flags: read clears, a same-cycle event wins
        if (flagRead) begin
            d.watchdog_flag = 1'b0; // R8
            d.af1 = 1'b0; // R23
            d.af2 = 1'b0;
            d.tf  = 1'b0; // R17
        end
        if (wdSet) begin
            d.watchdog_flag = 1'b1;
        end
        if (al1Set) begin
            d.af1 = 1'b1;
        end
        if (al2Set) begin
            d.af2 = 1'b1;
        end
        if (tmrEnd) begin
            d.tf = 1'b1; // R13
        end
        // countdown with reload; count is kept while stopped
        if (wrTval) begin
            d.tmrLoad = regReq.data;
            d.tmrCnt  = regReq.data;
        end else if (tmrRun & tmrTick) begin
            d.tmrCnt = tmrEnd ? q.tmrLoad : 8'(q.tmrCnt - 8'h01); // R13
        end
        if (regReq.write && regReq.addr == ADDR_TCTL) begin
            d.tmrCtl = regReq.data & CTL_MASK;
        end
        if (q.pfStable) begin
            d.tmrCtl[CTL_TE] = 1'b0; // R11
        end
        // pulse starts with the flag, flag clear does not stop it
        if (!pulseMode) begin
            d.pulseCnt = 11'h000; // R20
        end else if (tmrEnd) begin
            d.pulseCnt = pulseTicks(q.tmrCtl[1:0],
                                    q.tmrLoad == 8'h01); // R19
        end else if (presTick && q.pulseCnt != 11'h000) begin
            d.pulseCnt = 11'(q.pulseCnt - 11'h001);
        end
        // configuration and alarm two bytes
        if (regReq.write && regReq.addr == ADDR_CFG) begin
            d.cfg = regReq.data;
        end
        if (wrSram) begin
            d.sram[3'(regReq.addr - ADDR_AL2_FIRST)] = regReq.data; // R2
        end
        // read data, registered; unmapped reads give zero
        if (regReq.read) begin
            case (regReq.addr)
                ADDR_WDOG:  d.rdData = q.wdReg;
                ADDR_FLAGS: d.rdData = {q.watchdog_flag, q.af1, q.af2, batteryLowFlag,
                                        q.tf, oscFailFlag, 2'b00};
                ADDR_TVAL:  d.rdData = q.tmrCnt; // R15
                ADDR_TCTL:  d.rdData = q.tmrCtl;
                ADDR_CFG:   d.rdData = q.cfg;
                default: begin
                    d.rdData = wrSram | (regReq.addr >= ADDR_AL2_FIRST &&
                                         regReq.addr <= ADDR_AL2_LAST)
                        ? q.sram[3'(regReq.addr - ADDR_AL2_FIRST)]
                        : 8'h00;
                end
            endcase
        end
        // square wave, dropped on power fail
        d.sqOut = squareOutputEnable & !q.pfStable & (q.cfg[7:4] != 4'h0) &
                  q.presc[sqBit(q.cfg[7:4])]; // R22
        // frequency test has the pin, else any active source pulls low
        d.irqLow = ftOn ? !q.presc[FT_BIT] : (holdLow | tmrIrq); // R25
    end

    // state register; reset also clears the watchdog byte
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= RESET_STATE; // R9
        end else begin
            q <= d;
        end
    end

    assign regRdData       = q.rdData;
    assign squareOutputPin = q.sqOut;
    assign sharedIrqPinOut = 1'b0;
    assign sharedIrqPinOe  = q.irqLow;

    flagClear_a: assert property (@(posedge clk_sys) disable iff (rst) // R8
        flagRead && !wdSet |=> !q.watchdog_flag)
        else $error("watchdog flag survived flags read");
    wdRestart_a: assert property (@(posedge clk_sys) disable iff (rst) // R6
        wrWdog && regReq.data[6:2] != 5'h00 |=>
        q.wdCnt == 5'h00 && q.wdState == WD_RUN)
        else $error("watchdog write did not restart");
    wdRelease_a: assert property (@(posedge clk_sys) disable iff (rst) // R7
        wrWdog && regReq.data == 8'h00 |=>
        !q.wdIrq && q.wdState == WD_IDLE ##1
        (q.wdState == WD_IDLE || $past(wrWdog)))
        else $error("zero write did not release watchdog");
    tmrHold_a: assert property (@(posedge clk_sys) disable iff (rst) // R11
        !ctlTe && !wrTval |=> $stable(q.tmrCnt))
        else $error("timer moved while disabled");
    tmrZero_a: assert property (@(posedge clk_sys) disable iff (rst) // R14
        q.tmrLoad == 8'h00 |-> !tmrEnd)
        else $error("zero load produced a countdown end");
    tmrReload_a: assert property (@(posedge clk_sys) disable iff (rst) // R13
        tmrEnd |=> q.tf && q.tmrCnt == $past(q.tmrLoad))
        else $error("timer end without flag and reload");
    pulseLen_a: assert property (@(posedge clk_sys) disable iff (rst) // R19
        tmrEnd && pulseMode && q.tmrCtl[1:0] == 2'b00 &&
        q.tmrLoad > 8'h01 |=> q.pulseCnt == PULSE_4096)
        else $error("wrong pulse length at 4096 Hz");
    sqOff_a: assert property (@(posedge clk_sys) disable iff (rst) // R22
        q.pfStable || !squareOutputEnable |=> !squareOutputPin)
        else $error("square wave active while disabled");
    levelIrq_a: assert property (@(posedge clk_sys) disable iff (rst) // R18
        !ftOn && ctlTie && !ctlTp && q.tf |=> sharedIrqPinOe)
        else $error("level timer irq not driven");

endmodule

//--- rtl/rat_pkg.sv
// constants, types and state layout of the rtc auxiliary timers
package rat_pkg;

    // clocks and the 65536 Hz prescaler made by fractional division
    localparam int unsigned CLK_HZ   = 20000000;
    localparam int unsigned PRESC_HZ = 65536;
    localparam logic [24:0] ACC_MOD  = 25'(CLK_HZ);
    localparam logic [24:0] ACC_STEP = 25'(PRESC_HZ);

    // prescaler bit counts giving each tick rate
    localparam int unsigned DIV_4096 = 4;
    localparam int unsigned DIV_64   = 10;
    localparam int unsigned DIV_16HZ = 12;
    localparam int unsigned DIV_4HZ  = 14;
    localparam int unsigned DIV_1HZ  = 16;
    localparam int unsigned DIV_QHZ  = 18;
    localparam int unsigned FT_BIT   = 6;
    localparam logic [5:0]  MIN_LAST = 6'h3b;

    // pulse widths in prescaler ticks
    localparam logic [10:0] PULSE_8192 = 11'(PRESC_HZ / 8192);
    localparam logic [10:0] PULSE_4096 = 11'(PRESC_HZ / 4096);
    localparam logic [10:0] PULSE_128  = 11'(PRESC_HZ / 128);
    localparam logic [10:0] PULSE_64   = 11'(PRESC_HZ / 64);

    // register offsets
    localparam logic [4:0] ADDR_WDOG      = 5'h09;
    localparam logic [4:0] ADDR_FLAGS     = 5'h0f;
    localparam logic [4:0] ADDR_TVAL      = 5'h10;
    localparam logic [4:0] ADDR_TCTL      = 5'h11;
    localparam logic [4:0] ADDR_CFG       = 5'h13;
    localparam logic [4:0] ADDR_AL2_FIRST = 5'h14;
    localparam logic [4:0] ADDR_AL2_LAST  = 5'h18;
    localparam int unsigned SRAM_BYTES    = 5;

    // field positions and reset values
    localparam int unsigned FLG_WD  = 7;
    localparam int unsigned FLG_A1  = 6;
    localparam int unsigned FLG_A2  = 5;
    localparam int unsigned FLG_BL  = 4;
    localparam int unsigned FLG_TF  = 3;
    localparam int unsigned FLG_OF  = 2;
    localparam int unsigned CTL_TE  = 7;
    localparam int unsigned CTL_TP  = 6;
    localparam int unsigned CTL_TIE = 5;
    localparam logic [7:0]  CTL_MASK  = 8'he3;
    localparam logic [7:0]  CTL_RESET = 8'h03;
    localparam int unsigned CFG_ALARM_TWO_ENABLE  = 1;
    localparam logic [7:0]  CFG_RESET = 8'h10;
    localparam int unsigned WD_MULT_LSB = 2;
    localparam int unsigned RPT_BIT     = 7;

    // legal repeat codes, seconds field in bit 0
    localparam logic [4:0] RPT_SEC   = 5'h1f;
    localparam logic [4:0] RPT_MIN   = 5'h1e;
    localparam logic [4:0] RPT_HOUR  = 5'h1c;
    localparam logic [4:0] RPT_DAY   = 5'h18;
    localparam logic [4:0] RPT_MONTH = 5'h10;
    localparam logic [4:0] RPT_YEAR  = 5'h00;

    typedef enum logic [2:0] {
        WD_IDLE    = 3'b001,
        WD_RUN     = 3'b010,
        WD_EXPIRED = 3'b100
    } rat_wd_state_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [4:0] addr;
        logic [7:0] data;
    } rat_regreq_t;

    typedef struct packed {
        logic [24:0]                 presAcc;
        logic [17:0]                 presc;
        logic [5:0]                  minCnt;
        rat_wd_state_t               wdState;
        logic [7:0]                  wdReg;
        logic [4:0]                  wdCnt;
        logic                        wdIrq;
        logic                        watchdog_flag;
        logic                        af1;
        logic                        af2;
        logic                        tf;
        logic [7:0]                  tmrCtl;
        logic [7:0]                  tmrLoad;
        logic [7:0]                  tmrCnt;
        logic [10:0]                 pulseCnt;
        logic [7:0]                  cfg;
        logic [SRAM_BYTES-1:0][7:0]  sram;
        logic                        pfS1;
        logic                        pfS2;
        logic                        pfS3;
        logic                        pfStable;
        logic [7:0]                  rdData;
        logic                        sqOut;
        logic                        irqLow;
    } rat_state_t;

endpackage

//--- tb/rat_host_model.sv
// host side model: single byte register reads and writes on the strobes
`timescale 1ns/10ps
module rat_host_model
    import rat_pkg::*;
(
    input  wire logic       clk_sys,   // system clock
    output rat_regreq_t     regReq,    // request towards the device
    input  wire logic [7:0] regRdData  // registered read data
);
    initial begin
        regReq = '0;
    end

    // strobe set at a falling edge, held over one rising edge, then
    // dropped; idle addr/data are inverted so stale values never match
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regReq = '{write: 1'b1, read: 1'b0, addr: a, data: d};
        @(negedge clk_sys);
        regReq = '{write: 1'b0, read: 1'b0, addr: ~a, data: ~d};
    endtask

    // read data is registered at the taking edge itself, so it is
    // picked up at the falling edge that also drops the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        regReq = '{write: 1'b0, read: 1'b1, addr: a, data: 8'h00};
        @(negedge clk_sys);
        regReq = '{write: 1'b0, read: 1'b0, addr: ~a, data: 8'hff};
        d = regRdData;
    endtask
endmodule

//--- tb/rat_aux_timers_test.sv
// self-checking bench for the auxiliary timers block
`timescale 1ns/10ps
module rat_aux_timers_test
    import rat_pkg::*;
    ();
    logic        clk_sys, rst, staticOutBit, squareOutputEnable;
    logic        oscFailFlag, oscFailIrqEnable, batteryLowFlag, powerFailPin;
    rat_regreq_t regReq;
    logic [7:0]  regRdData, v, v2;
    logic        squareOutputPin, sharedIrqPinOut, sharedIrqPinOe;
    logic        freqTestEnable, alarmOneIrqEnable;
    int          fails, numChecks, t, w, n, e, hz;

    rat_aux_timers dut (
        .clk_sys           (clk_sys),
        .rst               (rst),
        .regReq            (regReq),
        .regRdData         (regRdData),
        .alarmOneMatch     (5'h00),
        .alarmTwoMatch     (5'h00),
        .alarmOneRepeat    (5'h00),
        .alarmOneIrqEnable (alarmOneIrqEnable),
        .oscFailFlag       (oscFailFlag),
        .oscFailIrqEnable  (oscFailIrqEnable),
        .batteryLowFlag    (batteryLowFlag),
        .staticOutBit      (staticOutBit),
        .freqTestEnable    (freqTestEnable),
        .squareOutputEnable(squareOutputEnable),
        .powerFailPin      (powerFailPin),
        .squareOutputPin   (squareOutputPin),
        .sharedIrqPinOut   (sharedIrqPinOut),
        .sharedIrqPinOe    (sharedIrqPinOe)
    );

    rat_host_model host (
        .clk_sys  (clk_sys),
        .regReq   (regReq),
        .regRdData(regRdData)
    );

    // 20 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check8(input string nm, input logic [7:0] ex,
                          input logic [7:0] got);
        numChecks++;
        if (got !== ex) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic checkRange(input string nm, input int lo, input int hi,
                              input int got);
        numChecks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi,
                     got);
        end
    endtask

    // cycles until the pin is pulled low, -1 if it never is
    task automatic waitOe(input int maxc, output int c);
        c = -1;
        for (int i = 0; i < maxc && c < 0; i++) begin
            @(negedge clk_sys);
            if (sharedIrqPinOe === 1'b1) c = i;
        end
    endtask

    // bounded so a stuck pin cannot hang the run
    task automatic widthOe(output int c);
        c = 0;
        while (sharedIrqPinOe === 1'b1 && c < 20000) begin
            @(negedge clk_sys);
            c++;
        end
    endtask

    task automatic countSq(input int span, output int c);
        logic last;
        c = 0;
        last = squareOutputPin;
        repeat (span) begin
            @(negedge clk_sys);
            if (squareOutputPin === 1'b1 && last !== 1'b1) c++;
            last = squareOutputPin;
        end
    endtask

    task automatic finalReport();
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard, above the summed timer waits of all scenarios
    initial begin
        repeat (95000) @(posedge clk_sys);
        fails++;
        $display("watchdog expired before the tests ended");
        finalReport();
    end

    initial begin
        fails = 0;
        numChecks = 0;
        rst = 1'b1;
        staticOutBit = 1'b1;
        squareOutputEnable = 1'b0;
        oscFailFlag = 1'b1;
        oscFailIrqEnable = 1'b0;
        batteryLowFlag = 1'b1;
        freqTestEnable = 1'b0;
        alarmOneIrqEnable = 1'b0;
        powerFailPin = 1'b0;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        // reset values, unmapped place, reserved control bits
        host.rd(ADDR_WDOG, v);
        check8("wdog reset", 8'h00, v);
        host.rd(ADDR_TCTL, v);
        check8("tctl reset", CTL_RESET, v);
        host.rd(ADDR_CFG, v);
        check8("cfg reset", CFG_RESET, v);
        host.rd(5'h1f, v);
        check8("unmapped", 8'h00, v);
        check8("pin level", 8'h00, {7'h00, sharedIrqPinOut});
        host.wr(ADDR_TCTL, 8'h1f);
        host.rd(ADDR_TCTL, v);
        check8("tctl rsvd", 8'h1f & CTL_MASK, v);
        // alarm-two bytes behave as plain storage while disabled
        for (int i = 0; i < SRAM_BYTES; i++)
            host.wr(ADDR_AL2_FIRST + 5'(i), 8'ha5 ^ 8'(i));
        for (int i = 0; i < SRAM_BYTES; i++) begin
            host.rd(ADDR_AL2_FIRST + 5'(i), v);
            check8("sram byte", 8'ha5 ^ 8'(i), v);
        end
        host.wr(ADDR_WDOG, 8'h0e);
        host.rd(ADDR_WDOG, v);
        check8("wdog value", 8'h0e, v);
        host.wr(ADDR_WDOG, 8'h00);
        host.rd(ADDR_WDOG, v);
        check8("wdog cleared", 8'h00, v);
        // static level, which an enabled alarm source takes away
        staticOutBit = 1'b0;
        repeat (2) @(negedge clk_sys);
        check8("static low", 8'h01, {7'h00, sharedIrqPinOe});
        alarmOneIrqEnable = 1'b1;
        repeat (2) @(negedge clk_sys);
        check8("alarm source", 8'h00, {7'h00, sharedIrqPinOe});
        alarmOneIrqEnable = 1'b0;
        staticOutBit = 1'b1;
        oscFailIrqEnable = 1'b1;
        repeat (2) @(negedge clk_sys);
        check8("osc fail irq", 8'h01, {7'h00, sharedIrqPinOe});
        oscFailIrqEnable = 1'b0;
        repeat (2) @(negedge clk_sys);
        check8("pin released", 8'h00, {7'h00, sharedIrqPinOe});
        // live count, then stop and hold; both waits together span a
        // half period of the test tone, which the armed watchdog denies
        freqTestEnable = 1'b1;
        host.wr(ADDR_WDOG, 8'h0e);
        host.wr(ADDR_TVAL, 8'h05);
        host.wr(ADDR_TCTL, 8'h80);
        waitOe(14000, t);
        checkRange("ft denied", -1, -1, t);
        host.rd(ADDR_TVAL, v);
        checkRange("live count", 2, 3, int'(v));
        host.wr(ADDR_TCTL, 8'h00);
        host.rd(ADDR_TVAL, v);
        waitOe(6000, t);
        checkRange("ft denied", -1, -1, t);
        host.rd(ADDR_TVAL, v2);
        check8("held count", v, v2);
        freqTestEnable = 1'b0;
        host.wr(ADDR_WDOG, 8'h00);
        // level mode: pin follows flag, timer value write keeps it
        host.wr(ADDR_TVAL, 8'h01);
        host.wr(ADDR_TCTL, 8'ha0);
        waitOe(12000, t);
        checkRange("level wait", 0, 5300, t);
        host.rd(ADDR_FLAGS, v);
        check8("flags", 8'h1c, v);
        @(negedge clk_sys);
        check8("level release", 8'h00, {7'h00, sharedIrqPinOe});
        waitOe(12000, t);
        host.wr(ADDR_TVAL, 8'h01);
        repeat (4) @(negedge clk_sys);
        check8("flag kept", 8'h01, {7'h00, sharedIrqPinOe});
        // pulse mode widths for a count of one and of two
        for (int i = 0; i < 2; i++) begin
            host.wr(ADDR_TCTL, 8'h00);
            host.rd(ADDR_FLAGS, v);
            host.wr(ADDR_TVAL, 8'(i + 1));
            host.wr(ADDR_TCTL, 8'he0);
            waitOe(12000, t);
            widthOe(w);
            e = (i == 0) ? 2441 : 4883;
            checkRange("pulse width", e - 10, e + 10, w);
            host.rd(ADDR_FLAGS, v);
            check8("pulse flag", 8'h1c, v);
            waitOe(12000, t);
            checkRange("pulse again", 0, 11000, t);
        end
        // zero load leaves the timer stopped; level mode would show an end
        host.wr(ADDR_TCTL, 8'h00);
        host.wr(ADDR_TVAL, 8'h00);
        host.rd(ADDR_FLAGS, v);
        host.wr(ADDR_TCTL, 8'ha0);
        waitOe(5300, t);
        checkRange("zero load", -1, -1, t);
        // square wave rates over 4000 cycles
        squareOutputEnable = 1'b1;
        for (int c = 0; c < 3; c++) begin
            host.wr(ADDR_CFG, {4'(c), 4'h0});
            hz = (c == 0) ? 0 : 32768 >> ((c == 1) ? 0 : c);
            e = hz / 5000;
            countSq(4000, n);
            checkRange("square edges", (c == 0) ? 0 : e - 1, e + 1, n);
        end
        host.wr(ADDR_CFG, 8'h10);
        powerFailPin = 1'b1;
        repeat (8) @(negedge clk_sys);
        countSq(2000, n);
        checkRange("square power fail", 0, 0, n);
        host.rd(ADDR_TCTL, v);
        check8("te power fail", 8'h20, v);
        powerFailPin = 1'b0;
        squareOutputEnable = 1'b0;
        repeat (8) @(negedge clk_sys);
        countSq(2000, n);
        checkRange("square disabled", 0, 0, n);
        finalReport();
    end
endmodule
